// File: rtl/slot_reset_defs.vh
`ifndef SLOT_RESET_DEFS_VH
`define SLOT_RESET_DEFS_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_DELAY 8'h04
`define OFS_TICK 8'h08
`define OFS_STATUS 8'h0c

// Control register fields
`define CTRL_PWR_OFF 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_RST_OE 3
`define CTRL_RESET 4'h1

// Delay register fields
`define DLY_P2R_LO 0
`define DLY_P2R_HI 15
`define DLY_R2P_LO 16
`define DLY_R2P_HI 31
`define DELAY_RESET 32'h0010_0010

// Tick divider, cycles per tick minus one
`define TICK_RESET 16'h0063

// Status register fields
`define STAT_RST 0
`define STAT_PE 1
`define STAT_PG 2
`define STAT_ST_LO 4
`define STAT_ST_HI 5
`define STAT_FAULT 8

// Reset mode encodings
`define MODE_PE 2'h0
`define MODE_PG 2'h1
`define MODE_HOT 2'h2

// Timing: minimum reset pulse, 200 us in 10 ns cycles
`define MIN_RST_PULSE_CYCLES 16'h4e20

`endif

// File: rtl/sync2.v
`timescale 1ns/10ps
module sync2 (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Async level in, synced level out
   input wire d,
   output wire q
);
   reg meta_reg;
   reg sync_reg;

   // Two-stage synchroniser
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
      end
   end

   assign q = sync_reg;
endmodule

// File: rtl/delay_count.v
`timescale 1ns/10ps
module delay_count (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Load and tick
   input wire load,
   input wire [15:0] value,
   input wire tick,
   // Expired
   output wire done
);
   reg [15:0] cnt_reg;
   reg [15:0] cnt_next;

   always @* begin
      cnt_next = cnt_reg;
      if (load) begin
         cnt_next = value;
      end else if (tick && (cnt_reg != 16'h0000)) begin
         cnt_next = cnt_reg - 16'h0001;
      end
   end

   // Counter register
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign done = (cnt_reg == 16'h0000) & ~load;
endmodule

// File: rtl/slot_reset_seq.v
`timescale 1ns/10ps
`include "slot_reset_defs.vh"
module slot_reset_seq #(
   parameter [15:0] MIN_PULSE_CYCLES = `MIN_RST_PULSE_CYCLES
) (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   // Hot reset request from port logic
   input wire hot_reset_in,
   // Slot pins
   input wire slot_power_good_in,
   output wire slot_reset_n_o,
   output wire slot_reset_n_oe,
   output wire slot_power_enable_out
);
   // Sequencer states
   localparam [1:0] ST_OFF = 2'd0;
   localparam [1:0] ST_UP = 2'd1;
   localparam [1:0] ST_ON = 2'd2;
   localparam [1:0] ST_DOWN = 2'd3;

   // Registers
   reg [3:0] ctrl_reg;
   reg [31:0] delay_reg;
   reg [15:0] tick_div_reg;
   reg fault_reg;
   reg wr_pend_reg;
   reg [7:0] wr_addr_reg;
   reg [31:0] hrdata_reg;
   // Sequencer state
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg rst_req_reg;
   reg rst_req_next;
   reg pe_reg;
   reg pe_next;
   reg pg_seen_reg;
   reg pg_seen_next;
   reg rst_out_reg;
   reg rst_out_next;
   reg [15:0] pulse_cnt_reg;
   reg [15:0] tick_cnt_reg;
   reg [15:0] tick_cnt_next;
   reg dly_load;
   reg dly_sel_r2p;
   reg fault_set;
   // Bus helpers
   reg [31:0] wdata_stat;
   wire addr_ok;
   wire fault_clr;
   wire pg_s;
   wire tick;
   wire dly_done;
   wire min_met;
   wire [1:0] mode;
   wire pwr_off;
   wire [15:0] dly_val;

   // Register read mux
   function [31:0] read_word;
      input [7:0] ofs;
      input [3:0] ctl;
      input [31:0] dly;
      input [15:0] tdiv;
      input [31:0] stat;
      begin
         case (ofs)
            `OFS_CTRL: read_word = {28'h0000000, ctl};
            `OFS_DELAY: read_word = dly;
            `OFS_TICK: read_word = {16'h0000, tdiv};
            `OFS_STATUS: read_word = stat;
            default: read_word = 32'h00000000;
         endcase
      end
   endfunction

   // Status word assembly
   always @* begin
      wdata_stat = 32'h00000000;
      wdata_stat[`STAT_RST] = rst_out_reg;
      wdata_stat[`STAT_PE] = pe_reg;
      wdata_stat[`STAT_PG] = pg_s;
      wdata_stat[`STAT_ST_HI:`STAT_ST_LO] = state_reg;
      wdata_stat[`STAT_FAULT] = fault_reg;
   end

   // Address phase accepted
   assign addr_ok = hsel & htrans[1] & hready;

   // AHB address and data phase handling
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h00000000;
      end else begin
         wr_pend_reg <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr_reg <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            hrdata_reg <= read_word(haddr[7:0], ctrl_reg, delay_reg,
               tick_div_reg, wdata_stat);
         end
      end
   end

   // Write one to fault bit clears it
   assign fault_clr = wr_pend_reg & (wr_addr_reg == `OFS_STATUS) &
      hwdata[`STAT_FAULT];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `CTRL_RESET;
         delay_reg <= `DELAY_RESET;
         tick_div_reg <= `TICK_RESET;
      end else if (wr_pend_reg) begin
         case (wr_addr_reg)
            `OFS_CTRL: ctrl_reg <= hwdata[3:0];
            `OFS_DELAY: delay_reg <= hwdata;
            `OFS_TICK: tick_div_reg <= hwdata[15:0];
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // Sticky fault flag, set wins
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= fault_set | (fault_reg & ~fault_clr);
      end
   end

   // Zero-wait OKAY slave
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   sync2 u_pg_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .d(slot_power_good_in),
      .q(pg_s)
   );

   assign mode = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
   assign pwr_off = ctrl_reg[`CTRL_PWR_OFF];

   assign tick = (tick_cnt_reg == 16'h0000);
   always @* begin
      if (dly_load) begin
         tick_cnt_next = tick_div_reg;
      end else if (tick) begin
         tick_cnt_next = tick_div_reg;
      end else begin
         tick_cnt_next = tick_cnt_reg - 16'h0001;
      end
   end

   // Delay source select
   assign dly_val = dly_sel_r2p ? delay_reg[`DLY_R2P_HI:`DLY_R2P_LO] :
      delay_reg[`DLY_P2R_HI:`DLY_P2R_LO];

   delay_count u_delay (
      .clk(hclk),
      .rst_n(hresetn),
      .load(dly_load),
      .value(dly_val),
      .tick(tick),
      .done(dly_done)
   );

   // Sequencer next state
   always @* begin
      state_next = state_reg;
      rst_req_next = rst_req_reg;
      pe_next = pe_reg;
      pg_seen_next = pg_seen_reg;
      dly_load = 1'b0;
      dly_sel_r2p = 1'b0;
      fault_set = 1'b0;
      if (mode == `MODE_HOT) begin
         rst_req_next = hot_reset_in;
         pe_next = ~pwr_off;
         state_next = pwr_off ? ST_OFF : ST_ON;
         pg_seen_next = 1'b0;
      end else begin
         case (state_reg)
            ST_OFF: begin
               rst_req_next = 1'b1;
               pe_next = 1'b0;
               if (!pwr_off) begin
                  pe_next = 1'b1;
                  pg_seen_next = 1'b0;
                  state_next = ST_UP;
                  dly_load = (mode != `MODE_PG);
               end
            end
            ST_UP: begin
               rst_req_next = 1'b1;
               if (pwr_off) begin
                  dly_load = 1'b1;
                  dly_sel_r2p = 1'b1;
                  state_next = ST_DOWN;
               end else if (mode == `MODE_PG && !pg_seen_reg) begin
                  if (pg_s) begin
                     dly_load = 1'b1;
                     pg_seen_next = 1'b1;
                  end
               end else if (mode == `MODE_PG && !pg_s) begin
                  pg_seen_next = 1'b0;
               end else if (dly_done) begin
                  rst_req_next = 1'b0;
                  state_next = ST_ON;
               end
            end
            ST_ON: begin
               rst_req_next = 1'b0;
               if (pwr_off) begin
                  rst_req_next = 1'b1;
                  dly_load = 1'b1;
                  dly_sel_r2p = 1'b1;
                  state_next = ST_DOWN;
               end else if (mode == `MODE_PG && !pg_s) begin
                  rst_req_next = 1'b1;
                  fault_set = 1'b1;
                  pg_seen_next = 1'b0;
                  state_next = ST_UP;
               end
            end
            ST_DOWN: begin
               rst_req_next = 1'b1;
               if (dly_done) begin
                  pe_next = 1'b0;
                  state_next = ST_OFF;
               end
            end
            default: begin
               state_next = ST_OFF;
            end
         endcase
      end
   end

   assign min_met = (pulse_cnt_reg >= (MIN_PULSE_CYCLES - 16'h0001));
   always @* begin
      rst_out_next = rst_req_next | (rst_out_reg & ~min_met);
   end

   // Sequencer registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_OFF;
         rst_req_reg <= 1'b1;
         pe_reg <= 1'b0;
         pg_seen_reg <= 1'b0;
         rst_out_reg <= 1'b1;
         tick_cnt_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         rst_req_reg <= rst_req_next;
         pe_reg <= pe_next;
         pg_seen_reg <= pg_seen_next;
         rst_out_reg <= rst_out_next;
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cnt_reg <= 16'h0000;
      end else if (!rst_out_reg) begin
         pulse_cnt_reg <= 16'h0000;
      end else if (!min_met) begin
         pulse_cnt_reg <= pulse_cnt_reg + 16'h0001;
      end
   end

   // Pin drive
   assign slot_reset_n_o = ~rst_out_reg;
   assign slot_reset_n_oe = ctrl_reg[`CTRL_RST_OE];
   assign slot_power_enable_out = pe_reg;
endmodule

// File: tb/slot_power_model.sv
`timescale 1ns/10ps
module slot_power_model (
   // Clock and reset
   input wire hclk,
   input wire hresetn,
   // Bench control: ramp length, injected fault
   input wire [7:0] ramp_len,
   input wire fail_req,
   // Slot supply pins
   input wire slot_power_enable_out,
   output reg slot_power_good_in
);
   reg [7:0] ramp_reg;
   // slow good level, collapses on loss
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_reg <= 8'h00;
         slot_power_good_in <= 1'b0;
      end else if (!slot_power_enable_out || fail_req) begin
         ramp_reg <= 8'h00;
         slot_power_good_in <= 1'b0;
      end else if (ramp_reg != ramp_len) begin
         ramp_reg <= ramp_reg + 8'h01;
      end else begin
         slot_power_good_in <= 1'b1;
      end
   end
endmodule

// File: tb/slot_reset_seq_chk.sv
`timescale 1ns/10ps
module slot_reset_seq_chk #(
   parameter [15:0] MIN_PULSE_CYCLES = 16'h4e20
) (
   // Clock, reset and bus
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   // Slot pins
   input wire slot_reset_n_o,
   input wire slot_reset_n_oe,
   input wire slot_power_enable_out
);
   reg [15:0] low_cnt_reg;
   // Write address phase accepted
   wire wr_taken = hsel && htrans[1] && hready && hwrite;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Cycles with slot reset asserted
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         low_cnt_reg <= 16'h0000;
      else if (slot_reset_n_o)
         low_cnt_reg <= 16'h0000;
      else if (low_cnt_reg != 16'hffff)
         low_cnt_reg <= low_cnt_reg + 16'h0001;
   end
   a_pin_undriven: assert property (
      $rose(hresetn) |-> !slot_reset_n_oe) else $error("pin driven");
   a_oe_by_write: assert property (
      $changed(slot_reset_n_oe) |-> $past(wr_taken, 2)) else $error("oe moved");
   a_pulse_min_len: assert property (
      $rose(slot_reset_n_o) |-> low_cnt_reg >= MIN_PULSE_CYCLES - 16'h0001)
      else $error("pulse short");
   a_pulse_hold: assert property (
      $fell(slot_reset_n_o) |=> !slot_reset_n_o [*8]) else $error("pulse cut");
   a_power_follows: assert property (
      $rose(slot_power_enable_out) |-> $past(wr_taken, 2) || $past(wr_taken, 3))
      else $error("power on unasked");
   a_reset_while_off: assert property (
      !slot_power_enable_out |-> !slot_reset_n_o) else $error("reset free while off");
   a_enable_first: assert property (
      $rose(slot_power_enable_out) |-> !slot_reset_n_o) else $error("reset freed early");
   a_reset_first: assert property (
      $fell(slot_power_enable_out) |-> !slot_reset_n_o && !$past(slot_reset_n_o))
      else $error("power cut first");
   c_power_on: cover property ($rose(slot_power_enable_out));
   c_release: cover property ($rose(slot_reset_n_o));
   c_power_off: cover property ($fell(slot_power_enable_out));
endmodule

bind slot_reset_seq slot_reset_seq_chk #(.MIN_PULSE_CYCLES(MIN_PULSE_CYCLES)) chk_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .slot_reset_n_o(slot_reset_n_o), .slot_reset_n_oe(slot_reset_n_oe),
   .slot_power_enable_out(slot_power_enable_out));

// File: tb/slot_reset_seq_tb.sv
`timescale 1ns/10ps
`include "slot_reset_defs.vh"
module slot_reset_seq_tb;
   localparam int MINP = 32'h14;
   localparam int TK = 32'h0;
   localparam int P2R = 32'h1e;
   localparam int R2P = 32'h3;
   localparam int PGD = 32'h5;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic hot_reset_in = 1'b0, fail_req = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [7:0] ramp_len = 8'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, x;
   wire [31:0] hrdata;
   wire hready, slot_reset_n_o, slot_reset_n_oe, slot_power_enable_out, slot_power_good_in;
   wire hresp;
   // Pull-down keeps a released pin low
   wire slot_pin = slot_reset_n_oe ? slot_reset_n_o : 1'b0;
   int bad_count = 0, cmp_count = 0, cyc = 0, n;
   slot_reset_seq #(.MIN_PULSE_CYCLES(16'h0014)) slot_reset_seq_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .hot_reset_in(hot_reset_in),
      .slot_power_good_in(slot_power_good_in), .slot_reset_n_o(slot_reset_n_o),
      .slot_reset_n_oe(slot_reset_n_oe), .slot_power_enable_out(slot_power_enable_out));
   slot_power_model slot_power_model_inst (
      .hclk(hclk), .hresetn(hresetn), .ramp_len(ramp_len), .fail_req(fail_req),
      .slot_power_enable_out(slot_power_enable_out),
      .slot_power_good_in(slot_power_good_in));
   // Core clock
   always #5 hclk = ~hclk;
   // Hang guard
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         close_out;
      end
   end
   // Compare and count
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict
   task close_out;
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One single word transfer
   task bus(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, ofs};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      x = hrdata;
   endtask
   // Edges until a slot signal reaches a level
   task wait_sig(input int sel, input logic lvl);
      logic [2:0] v;
      n = 0;
      v = {slot_power_good_in, slot_power_enable_out, slot_reset_n_o};
      while (v[sel] !== lvl) begin
         @(posedge hclk);
         n++;
         v = {slot_power_good_in, slot_power_enable_out, slot_reset_n_o};
      end
   endtask
   // Reset state and defaults
   task t_reset;
      check("oe", 32'(slot_reset_n_oe), 32'h0);
      check("pin", 32'(slot_pin), 32'h0);
      check("pe", 32'(slot_power_enable_out), 32'h0);
      bus(1'b0, `OFS_CTRL, 32'h0);
      check("ctrl", x, 32'(`CTRL_RESET));
      check("hresp", 32'(hresp), 32'h0);
      bus(1'b0, `OFS_DELAY, 32'h0);
      check("delay", x, `DELAY_RESET);
      bus(1'b1, 8'h10, 32'hffffffff);
      bus(1'b0, 8'h10, 32'h0);
      check("unmapped", x, 32'h0);
   endtask
   // Power-enable mode spacing, then early release stretched
   task t_mode0;
      bus(1'b1, `OFS_TICK, 32'h0);
      bus(1'b1, `OFS_DELAY, {R2P[15:0], P2R[15:0]});
      bus(1'b1, `OFS_CTRL, 32'h8);
      wait_sig(1, 1'b1);
      check("rst at pe", 32'(slot_reset_n_o), 32'h0);
      wait_sig(0, 1'b1);
      check("p2r", n, P2R * (TK + 32'h1) + 32'h1);
      check("pin on", 32'(slot_pin), 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h9);
      wait_sig(0, 1'b0);
      check("pe at rst", 32'(slot_power_enable_out), 32'h1);
      wait_sig(1, 1'b0);
      check("r2p", n, R2P * (TK + 32'h1) + 32'h1);
      bus(1'b1, `OFS_DELAY, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h8);
      wait_sig(0, 1'b1);
      check("min pulse", 32'(n + 32'h8 >= MINP), 32'h1);
      bus(1'b1, `OFS_CTRL, 32'h9);
      wait_sig(1, 1'b0);
   endtask
   // Power-good mode release and fault
   task t_mode1;
      ramp_len <= 8'h28;
      bus(1'b1, `OFS_DELAY, {16'h0003, PGD[15:0]});
      bus(1'b1, `OFS_CTRL, 32'ha);
      wait_sig(2, 1'b1);
      check("rst pre good", 32'(slot_reset_n_o), 32'h0);
      wait_sig(0, 1'b1);
      check("g2r", n, 32'h3 + PGD * (TK + 32'h1) + 32'h1);
      fail_req <= 1'b1;
      wait_sig(0, 1'b0);
      check("fault", n, 32'h5);
      bus(1'b0, `OFS_STATUS, 32'h0);
      check("fault bit", 32'(x[`STAT_FAULT]), 32'h1);
      bus(1'b1, `OFS_STATUS, 32'h100);
      bus(1'b0, `OFS_STATUS, 32'h0);
      check("fault clr", 32'(x[`STAT_FAULT]), 32'h0);
      fail_req <= 1'b0;
      wait_sig(0, 1'b1);
   endtask
   // Hot-reset mode, short request stretched
   task t_hot;
      bus(1'b1, `OFS_CTRL, 32'hc);
      hot_reset_in <= 1'b1;
      @(posedge hclk);
      hot_reset_in <= 1'b0;
      wait_sig(0, 1'b0);
      check("hot lat", n, 32'h1);
      wait_sig(0, 1'b1);
      check("hot width", 32'(n >= MINP), 32'h1);
      check("hot pe", 32'(slot_power_enable_out), 32'h1);
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_mode0;
      t_mode1;
      t_hot;
      close_out;
   end
endmodule
